//--- pkg/ufil_params.svh
// Operation
// [RQ1] auto RTS drops when RX count reaches trigger
// [RQ2] auto CTS sends only while CTS active
// [RQ3] CTS auto enable and CTS active level bits
// [RQ4] any CTS change sets changed flag
// [RQ5] RTS pin polarity select, pin level readable
// [RQ6] software RTS bit drives RTS when manual
// [RQ7] function select 10 gives half-duplex IrDA
// [RQ8] bit rate is clock over sixteen times divisor
// [RQ9] IrDA encoder: 3/16 pulse per zero bit
// [RQ10] IrDA decoder with receive invert bit
// [RQ11] function select 01 gives LIN master
// [RQ12] LIN byte: start, eight LSB first, stop
// [RQ13] software sets 8N1 before LIN use
// [RQ14] header select: break, +sync, +identifier
// [RQ15] software writes sync/identifier per header select; code sends sync 8'h55 itself, software writes only the identifier field
// [RQ16] send header bit cleared when header done
// [RQ17] bit monitor flags RX differing from TX
// [RQ18] break twelve bits, delimiter one, both programmable
// [RQ19] inter-byte gap one bit, programmable
// [RQ20] identifier parity by software or hardware
// [RQ21] monitored header: break only, await detect
// [RQ22] software reads back each sent byte
// [RQ23] break detect: over eleven low bits, then high
// [RQ24] hardware parity per LIN identifier equations
// [RQ25] auto RTS returns below trigger level
`ifndef UFIL_PARAMS_SVH
`define UFIL_PARAMS_SVH
// register byte offsets
`define UFIL_A_DATA   8'h00
`define UFIL_A_FCR    8'h04
`define UFIL_A_IER    8'h08
`define UFIL_A_MCR    8'h0C
`define UFIL_A_MSR    8'h10
`define UFIL_A_BAUD   8'h14
`define UFIL_A_LIN    8'h18
`define UFIL_A_LINSR  8'h1C
`define UFIL_A_TOR    8'h20
`define UFIL_A_FUN    8'h24
`define UFIL_A_IRCR   8'h28
`define UFIL_A_FSR    8'h2C
// writable bit masks
`define UFIL_M_FCR    32'h000F0000
`define UFIL_M_IER    32'h00003000
`define UFIL_M_MCR    32'h00000302
`define UFIL_M_BAUD   32'h2000FFFF
`define UFIL_M_LIN    32'hFFFF1700
`define UFIL_M_TOR    32'h000000FF
`define UFIL_M_FUN    32'h00000003
`define UFIL_M_IRCR   32'h00000040
// reset values
`define UFIL_R_LIN    32'h000B0000
`define UFIL_R_IRCR   32'h00000040
// field positions
`define UFIL_F_TRIG   19:16
`define UFIL_F_BKFL   19:16
`define UFIL_F_BSLEN  21:20
`define UFIL_F_HSEL   23:22
`define UFIL_F_PID    31:24
`define UFIL_F_DLY    7:0
`define UFIL_F_DIV    15:0
`define UFIL_B_SWRTS  1
`define UFIL_B_CTSLV  8
`define UFIL_B_RTSPOL 9
`define UFIL_B_ARTS   12
`define UFIL_B_ACTS   13
`define UFIL_B_SHD    8
`define UFIL_B_IDPEN  9
`define UFIL_B_BKDEN  10
`define UFIL_B_BEREN  12
`define UFIL_B_RXINV  6
`define UFIL_B_BKDF   8
`define UFIL_B_BERF   9
// timing and codes, in 16x ticks or bits
`define UFIL_SYNC     8'h55
`define UFIL_FRAME    9'h00A
`define UFIL_IR_PULSE 4'h3
`define UFIL_BRK_TCK  8'hB0
`define UFIL_MID      4'h7
`define UFIL_CHK      4'h8
`define UFIL_STOPBIT  4'h9
`endif

//--- pkg/ufil_pkg.sv
package ufil_pkg;
  // header sequencer, gray along break-delim-sync-id
  typedef enum logic [2:0] {
    ufil_h_idle = 3'h0,
    ufil_h_brk  = 3'h1,
    ufil_h_del  = 3'h3,
    ufil_h_sync = 3'h2,
    ufil_h_pid  = 3'h6
  } ufil_hdr_t;
  // function select codes
  typedef enum logic [1:0] {
    ufil_f_uart = 2'h0,
    ufil_f_lin  = 2'h1,
    ufil_f_irda = 2'h2
  } ufil_fun_t;
endpackage

//--- pkg/ufil_ser_if.sv
`timescale 1ns/1ps
interface ufil_ser_if;
  logic       tick;   // 16x baud enable
  logic       start;  // load a segment
  logic       fill;   // level shifted in behind
  logic [9:0] word;   // bits, lsb first
  logic [8:0] nbits;  // segment length in bits
  logic       busy;
  logic       done;   // last tick of segment
  logic       txd;    // nrz line
  logic [3:0] sub;    // tick within bit
  modport ctl (output tick, start, fill, word, nbits, input busy, done, txd, sub);
  modport ser (input tick, start, fill, word, nbits, output busy, done, txd, sub);
endinterface

//--- rtl/ufil_ser.sv
`timescale 1ns/1ps
module ufil_ser
(
  input wire logic aclk,
  input wire logic aresetn,
  ufil_ser_if.ser  sif
);
  logic [9:0] sh_r;   // outgoing bits
  logic [8:0] cnt_r;  // bits left
  logic [3:0] sub_r;  // tick in bit
  logic       busy_r;
  logic       fill_r;

  ////////////////////////////////////////////////////////////////////
  // bit end decode
  wire bit_end = sif.tick & busy_r & (sub_r == 4'hF);
  assign sif.done = bit_end & (cnt_r == 9'h001);
  assign sif.busy = busy_r;
  assign sif.txd  = busy_r ? sh_r[0] : 1'b1;
  assign sif.sub  = sub_r;

  ////////////////////////////////////////////////////////////////////
  // shifter; a new load wins over the finishing bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_r   <= 10'h3FF;
      cnt_r  <= 9'h000;
      sub_r  <= 4'h0;
      busy_r <= 1'b0;
      fill_r <= 1'b1;
    end
    else if (sif.start)
    begin
      sh_r   <= sif.word;
      cnt_r  <= sif.nbits;
      fill_r <= sif.fill;
      sub_r  <= 4'h0;
      busy_r <= 1'b1;
    end
    else if (busy_r && sif.tick)
    begin
      sub_r <= sub_r + 4'h1;
      if (bit_end)
      begin
        // lsb first, fill level extends break or gap
        sh_r   <= {fill_r, sh_r[9:1]}; // RQ12
        cnt_r  <= cnt_r - 9'h001;
        busy_r <= cnt_r != 9'h001;
      end
    end
  end
endmodule // ufil_ser

//--- rtl/ufil_top.sv
`timescale 1ns/1ps
`include "ufil_params.svh"
module ufil_top
#(
  parameter int RX_DEPTH = 16  // receive fifo words, power of two
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic        rx_pin,
  input  wire logic        cts_pin,
  output wire logic        tx_pin,
  output wire logic        rts_pin
);
  import ufil_pkg::*;
  localparam int CW = $clog2(RX_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input logic [31:0] m);
    logic [31:0] be;
    be = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return ((old & ~be) | (d & be)) & m;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `UFIL_A_FSR);
  endfunction
  function automatic logic [7:0] pid_calc(input logic [7:0] p, input logic hw);
    return hw ? {~(p[1] ^ p[3] ^ p[4] ^ p[5]), p[0] ^ p[1] ^ p[2] ^ p[4], p[5:0]} : p;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] fcr_r, ier_r, mcr_r, baud_r, lin_r, tor_r, ircr_r; // control words
  ufil_fun_t   fun_r;                     // function select
  logic        msr_r;                     // cts changed flag
  logic        bkdet_f_r, biterr_f_r;     // lin status flags
  logic [7:0]  thr_r;                     // transmit holding
  logic        thr_v_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0]  w_strb_r;
  logic [15:0] div_cnt_r;                 // baud divider
  logic        cts_q_r;                   // cts one cycle ago
  logic        rts_pin_r, tx_pin_r;
  logic [4:0]  ir_hold_r;                 // decoder stretch, in ticks
  logic        rx_busy_r;
  logic        rx_last_r;                 // line level at previous tick
  logic [3:0]  rx_sub_r, rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  rx_mem [RX_DEPTH];         // receive fifo
  logic [CW-2:0] rx_wp_r, rx_rp_r;
  logic [CW-1:0] rx_cnt_r;
  logic [7:0]  lo_cnt_r;                  // low ticks for break detect
  ufil_hdr_t   hdr_r, hdr_nxt;
  logic [31:0] rd_word;

  ufil_ser_if sif ();
  ufil_ser u_ser (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif.ser)
  );

  ////////////////////////////////////////////////////////////////////
  // decode
  wire        lin_mode  = fun_r == ufil_f_lin;    // RQ11
  wire        irda_mode = fun_r == ufil_f_irda;   // RQ7
  wire [15:0] div       = baud_r[`UFIL_F_DIV];
  wire [15:0] div_m1    = (div == 16'h0) ? 16'h0 : div - 16'h1;
  wire        tick      = div_cnt_r >= div_m1;    // RQ8
  wire [3:0]  trig      = fcr_r[`UFIL_F_TRIG];
  wire [1:0]  hsel      = lin_r[`UFIL_F_HSEL];
  wire [7:0]  pid       = lin_r[`UFIL_F_PID];
  wire        shd       = lin_r[`UFIL_B_SHD];
  wire        wr_go     = ~awready_r & ~wready_r & ~bvalid_r;
  wire        ar_take   = arvalid & arready_r;
  wire        we_lin    = wr_go & (aw_addr_r == `UFIL_A_LIN);
  wire        we_data   = wr_go & (aw_addr_r == `UFIL_A_DATA) & w_strb_r[0];
  wire        w1c_msr   = wr_go & (aw_addr_r == `UFIL_A_MSR) & w_strb_r[0] & w_data_r[0];
  wire        w1c_sr    = wr_go & (aw_addr_r == `UFIL_A_LINSR) & w_strb_r[1];
  // cts gate only applies while auto cts is on
  wire        cts_ok    = ~ier_r[`UFIL_B_ACTS] | (cts_pin == mcr_r[`UFIL_B_CTSLV]); // RQ2 RQ3
  // internal rts: fifo level or software bit
  wire        rts_int   = ier_r[`UFIL_B_ARTS] ? (rx_cnt_r < CW'(trig))      // RQ1 RQ25
                                              : mcr_r[`UFIL_B_SWRTS];        // RQ6
  wire        rx_full   = rx_cnt_r == CW'(RX_DEPTH);
  wire        rx_pop    = ar_take & (araddr == `UFIL_A_DATA) & (rx_cnt_r != '0);
  // half duplex: receiver blind while sending
  wire        rx_in     = irda_mode ? (sif.busy | ir_hold_r == 5'h00) : rx_pin; // RQ7 RQ10
  wire        ir_low    = ircr_r[`UFIL_B_RXINV] ? ~rx_pin : rx_pin;         // RQ10
  wire        rx_push   = tick & rx_busy_r & (rx_sub_r == `UFIL_MID)
                          & (rx_bit_r == `UFIL_STOPBIT) & rx_in & ~rx_full;
  wire        bkdet_set = tick & rx_pin & (lo_cnt_r > `UFIL_BRK_TCK)
                          & lin_mode & lin_r[`UFIL_B_BKDEN];                 // RQ23
  wire        biterr_chk = lin_mode & lin_r[`UFIL_B_BEREN] & sif.busy & tick
                          & (sif.sub == `UFIL_CHK) & (tx_pin_r != rx_pin);   // RQ17
  wire        tx_empty  = ~thr_v_r & ~sif.busy & (hdr_r == ufil_h_idle);

  ////////////////////////////////////////////////////////////////////
  // header sequencing and segment selection
  wire hdr_go  = (hdr_r == ufil_h_idle) & lin_mode & shd & ~sif.busy;        // RQ16
  wire ld_del  = (hdr_r == ufil_h_brk) & sif.done;                           // RQ18
  wire ld_sync = (hdr_r == ufil_h_del) & sif.done & (hsel != 2'h0);          // RQ14
  wire ld_pid  = (hdr_r == ufil_h_sync) & sif.done & (hsel == 2'h2);         // RQ14
  wire hdr_end = sif.done & (((hdr_r == ufil_h_del) & (hsel == 2'h0))
                 | ((hdr_r == ufil_h_sync) & (hsel != 2'h2)) | (hdr_r == ufil_h_pid));
  wire ld_thr  = (hdr_r == ufil_h_idle) & ~hdr_go & ~(lin_mode & shd)
                 & thr_v_r & ~sif.busy & cts_ok;                             // RQ2
  wire [7:0] byte_sel = ld_sync ? `UFIL_SYNC
                      : ld_pid  ? pid_calc(pid, lin_r[`UFIL_B_IDPEN]) : thr_r; // RQ20 RQ24
  assign hdr_nxt = hdr_go  ? ufil_h_brk
                 : ld_del  ? ufil_h_del
                 : ld_sync ? ufil_h_sync
                 : ld_pid  ? ufil_h_pid
                 : hdr_end ? ufil_h_idle : hdr_r;
  assign sif.tick  = tick;
  assign sif.start = hdr_go | ld_del | ld_sync | ld_pid | ld_thr;
  assign sif.fill  = ~hdr_go;
  // break low, delimiter high, bytes framed 0-data-1 then gap
  assign sif.word  = hdr_go ? 10'h000 : ld_del ? 10'h3FF : {1'b1, byte_sel, 1'b0}; // RQ12
  assign sif.nbits = hdr_go ? 9'(lin_r[`UFIL_F_BKFL]) + 9'h001                      // RQ18
                   : ld_del ? 9'(lin_r[`UFIL_F_BSLEN]) + 9'h001
                   : `UFIL_FRAME + 9'(tor_r[`UFIL_F_DLY]) + 9'h001;               // RQ19

  // header state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hdr_r <= ufil_h_idle;
    else
      hdr_r <= hdr_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // pins: rzi pulse over first 3/16 of each zero bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_pin_r  <= 1'b1;
      rts_pin_r <= 1'b0;
      cts_q_r   <= 1'b0;
    end
    else
    begin
      tx_pin_r  <= irda_mode ? (sif.busy & ~sif.txd & (sif.sub < `UFIL_IR_PULSE)) // RQ9
                             : sif.txd;
      rts_pin_r <= mcr_r[`UFIL_B_RTSPOL] ? rts_int : ~rts_int;                  // RQ5
      cts_q_r   <= cts_pin;
    end
  end
  assign tx_pin  = tx_pin_r;
  assign rts_pin = rts_pin_r;

  ////////////////////////////////////////////////////////////////////
  // baud divider, decoder stretch, break low counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_r <= 16'h0;
      ir_hold_r <= 5'h00;
      lo_cnt_r  <= 8'h00;
      rx_last_r <= 1'b1;
    end
    else
    begin
      div_cnt_r <= tick ? 16'h0 : div_cnt_r + 16'h1;
      // a pulse stretches to one bit of nrz zero
      if (ir_low)
        ir_hold_r <= 5'h10;
      else if (tick && ir_hold_r != 5'h00)
        ir_hold_r <= ir_hold_r - 5'h01;
      if (tick)
      begin
        lo_cnt_r  <= rx_pin ? 8'h00 : lo_cnt_r + {7'h00, lo_cnt_r != 8'hFF};
        // idle high after reset, so no false start edge
        rx_last_r <= rx_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver; mid-bit sampling at tick 7
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_busy_r <= 1'b0;
      rx_sub_r  <= 4'h0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
    end
    else if (tick && !rx_busy_r)
    begin
      // start only on a falling edge; a long break yields one frame, not a train
      rx_busy_r <= ~rx_in & rx_last_r; // RQ10
      rx_sub_r  <= 4'h0;
      rx_bit_r  <= 4'h0;
    end
    else if (tick)
    begin
      rx_sub_r <= rx_sub_r + 4'h1;
      if (rx_sub_r == `UFIL_MID)
      begin
        rx_bit_r <= rx_bit_r + 4'h1;
        rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
        // false start or stop bit ends the byte
        if ((rx_bit_r == 4'h0 && rx_in) || rx_bit_r == `UFIL_STOPBIT)
          rx_busy_r <= 1'b0;
      end
    end
  end

  // receive fifo; overflow drops the new byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
    end
    else
    begin
      if (rx_push)
        rx_mem[rx_wp_r] <= rx_sh_r;
      rx_wp_r  <= rx_wp_r + (CW-1)'(rx_push);
      rx_rp_r  <= rx_rp_r + (CW-1)'(rx_pop);
      rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // axi4-lite channels, one write and one read in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0;
    end
    else
    begin
      if (awvalid && awready_r)
      begin
        awready_r <= 1'b0;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready_r)
      begin
        wready_r <= 1'b0;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      // unmapped answers slverr
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(aw_addr_r) ? 2'h0 : 2'h2;
      end
      else if (bvalid_r && bready)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
      if (ar_take)
      begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_word;
        rresp_r   <= mapped(araddr) ? 2'h0 : 2'h2;
      end
      else if (rvalid_r && rready)
      begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end
  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  // read selection
  always_comb
  begin
    unique case (araddr)
      `UFIL_A_DATA:  rd_word = {24'h0, rx_mem[rx_rp_r]};
      `UFIL_A_FCR:   rd_word = fcr_r;
      `UFIL_A_IER:   rd_word = ier_r;
      `UFIL_A_MCR:   rd_word = mcr_r | {18'h0, rts_pin_r, 13'h0}; // RQ5
      `UFIL_A_MSR:   rd_word = {31'h0, msr_r};
      `UFIL_A_BAUD:  rd_word = baud_r;
      `UFIL_A_LIN:   rd_word = lin_r;
      `UFIL_A_LINSR: rd_word = {22'h0, biterr_f_r, bkdet_f_r, 8'h0};
      `UFIL_A_TOR:   rd_word = tor_r;
      `UFIL_A_FUN:   rd_word = {30'h0, fun_r};
      `UFIL_A_IRCR:  rd_word = ircr_r;
      `UFIL_A_FSR:   rd_word = {3'h0, tx_empty, 27'h0, rx_cnt_r != '0};
      default:       rd_word = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // register file; hardware set beats software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fcr_r      <= 32'h0;
      ier_r      <= 32'h0;
      mcr_r      <= 32'h0;
      baud_r     <= 32'h0;
      lin_r      <= `UFIL_R_LIN;
      tor_r      <= 32'h0;
      ircr_r     <= `UFIL_R_IRCR;
      fun_r      <= ufil_f_uart;
      msr_r      <= 1'b0;
      bkdet_f_r  <= 1'b0;
      biterr_f_r <= 1'b0;
      thr_r      <= 8'h00;
      thr_v_r    <= 1'b0;
    end
    else
    begin
      if (wr_go && aw_addr_r == `UFIL_A_FCR)
        fcr_r <= wmerge(fcr_r, w_data_r, w_strb_r, `UFIL_M_FCR);
      if (wr_go && aw_addr_r == `UFIL_A_IER)
        ier_r <= wmerge(ier_r, w_data_r, w_strb_r, `UFIL_M_IER);
      if (wr_go && aw_addr_r == `UFIL_A_MCR)
        mcr_r <= wmerge(mcr_r, w_data_r, w_strb_r, `UFIL_M_MCR);
      if (wr_go && aw_addr_r == `UFIL_A_BAUD)
        baud_r <= wmerge(baud_r, w_data_r, w_strb_r, `UFIL_M_BAUD);
      if (wr_go && aw_addr_r == `UFIL_A_TOR)
        tor_r <= wmerge(tor_r, w_data_r, w_strb_r, `UFIL_M_TOR);
      if (wr_go && aw_addr_r == `UFIL_A_IRCR)
        ircr_r <= wmerge(ircr_r, w_data_r, w_strb_r, `UFIL_M_IRCR);
      if (wr_go && aw_addr_r == `UFIL_A_FUN && w_strb_r[0])
        fun_r <= ufil_fun_t'(w_data_r[1:0]);
      // software write wins over the hardware request clear
      if (we_lin)
        lin_r <= wmerge(lin_r, w_data_r, w_strb_r, `UFIL_M_LIN);
      else if (hdr_end)
        lin_r[`UFIL_B_SHD] <= 1'b0;                                  // RQ16
      msr_r      <= (cts_q_r != cts_pin) | (msr_r & ~w1c_msr);      // RQ4
      bkdet_f_r  <= bkdet_set | (bkdet_f_r & ~(w1c_sr & w_data_r[`UFIL_B_BKDF]));
      biterr_f_r <= biterr_chk | (biterr_f_r & ~(w1c_sr & w_data_r[`UFIL_B_BERF]));
      // one-deep holding; new write replaces a taken byte
      if (we_data)
        thr_r <= w_data_r[7:0];
      thr_v_r <= we_data | (thr_v_r & ~ld_thr);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rts_trig_drop: // RQ1
    assert property (ier_r[12] && rx_cnt_r >= CW'(trig) |=> rts_pin_r == !$past(mcr_r[9]))
      else $error("auto rts not dropped at trigger");
  a_rts_below_up: // RQ25
    assert property (ier_r[12] && rx_cnt_r < CW'(trig) |=> rts_pin_r == $past(mcr_r[9]))
      else $error("auto rts not raised below trigger");
  a_rts_soft_copy: // RQ6
    assert property (!ier_r[12] |=> rts_pin_r == ($past(mcr_r[1]) ~^ $past(mcr_r[9])))
      else $error("software rts not on pin");
  a_cts_hold_tx: // RQ2
    assert property (ier_r[13] && cts_pin != mcr_r[8] |-> !ld_thr)
      else $error("byte sent without cts");
  a_cts_change_flag: // RQ4
    assert property (cts_q_r != cts_pin |=> msr_r)
      else $error("cts change not flagged");
  a_baud_pace: // RQ8
    assert property (tick && div_m1 == 16'h1 && $stable(baud_r) |=> !tick ##1 tick)
      else $error("tick spacing wrong");
  a_ir_dark_idle: // RQ9
    assert property (irda_mode && (!sif.busy || sif.txd) |=> !tx_pin_r)
      else $error("irda light outside zero bit");
  a_ir_half_dup: // RQ7
    assert property (irda_mode && sif.busy |-> rx_in)
      else $error("irda receiving while sending");
  a_sync_frame: // RQ12
    assert property (ld_sync |-> sif.word == 10'h2AA && sif.fill)
      else $error("sync byte framing wrong");
  a_pid_parity: // RQ24
    assert property (ld_pid && lin_r[9] |-> sif.word[8] == !(pid[1] ^ pid[3] ^ pid[4] ^ pid[5])
                     && sif.word[7] == (pid[0] ^ pid[1] ^ pid[2] ^ pid[4]))
      else $error("identifier parity wrong");
  a_break_low: // RQ18
    assert property (hdr_r == ufil_h_brk && sif.busy && !irda_mode |=> !tx_pin_r)
      else $error("break not dominant");
  a_shd_clear: // RQ16
    assert property (hdr_end && !we_lin |=> !lin_r[8] && hdr_r == ufil_h_idle)
      else $error("send header not cleared");
  a_bit_err_flag: // RQ17
    assert property (biterr_chk |=> biterr_f_r)
      else $error("bit error not flagged");

  c_full_header:  cover property (hdr_end && hsel == 2'h2);
  c_break_seen:   cover property (bkdet_set);
  c_cts_stall:    cover property (thr_v_r && !cts_ok && !sif.busy);
  c_rts_dropped:  cover property (ier_r[12] && rx_cnt_r == CW'(trig));
endmodule // ufil_top

//--- dv/ufil_bus_model.sv
`timescale 1ns/1ps
module ufil_bus_model
(
  input  wire logic aclk,
  input  wire logic tx_pin,
  input  wire logic cts_lvl,
  output logic      rx_pin,
  output logic      cts_pin
);
  // idle wire and modem not yet ready
  initial rx_pin = 1'b1;
  initial cts_pin = 1'b0;
  // one-wire bus: the master hears its own bits back one clock late
  always @(posedge aclk)
  begin
    rx_pin  <= tx_pin;
    cts_pin <= cts_lvl;
  end
endmodule // ufil_bus_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        cts_lvl = 1'b0;  // modem side clear-to-send
  logic        ir_on = 1'b0;    // count light ticks
  int          ir_hi = 0;
  int          failures = 0;
  int          cmp_count = 0;
  logic [31:0] v;               // last read data
  logic [31:0] r;               // last response code
  wire logic   awready, wready, bvalid, arready, rvalid, rx_pin, cts_pin, tx_pin, rts_pin;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  ufil_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rx_pin, .cts_pin, .tx_pin, .rts_pin);
  ufil_bus_model model (.aclk, .tx_pin, .cts_lvl, .rx_pin, .cts_pin);
  initial
  begin
    forever #2 aclk = ~aclk;
  end
  // light ticks on the infrared output
  always @(posedge aclk)
    if (ir_on && tx_pin === 1'b1) ir_hi <= ir_hi + 1;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // each channel released at the edge its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    r = 32'(bresp);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    v = rdata;
    r = 32'(rresp);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic lv);
    for (int n = 0; n < 400; n++)
    begin
      rd(a);
      if (v[b] === lv) break;
    end
  endtask
  // read up to eight bytes from the receive fifo until it is empty, keeping the newest byte
  task automatic drain(output logic [7:0] last);
    last = 8'h00;
    for (int n = 0; n < 8; n++)
    begin
      rd(8'h2C);
      if (v[0] !== 1'b1) break;
      rd(8'h00);
      last = v[7:0];
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well past the longest header plus polling
  initial
  begin
    repeat (40000) @(posedge aclk);
    failures++;
    final_report();
  end
  initial
  begin
    logic [7:0] last;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h18);
    chk("lin reset", v, 32'h000B0000);
    rd(8'h28);
    chk("ircr reset", v, 32'h00000040);
    rd(8'h30);
    chk("unmapped", r, 32'h2);
    wr(8'h0C, 32'h00000202);
    chk("rts pin true", 32'(rts_pin), 32'h1);
    rd(8'h0C);
    chk("rts status", v, 32'h00002202);
    wr(8'h0C, 32'h00000002);
    chk("rts pin inverse", 32'(rts_pin), 32'h0);
    $display("test rts done");
    wr(8'h14, 32'h00000001);
    wr(8'h04, 32'h00010000);
    wr(8'h0C, 32'h00000300);
    wr(8'h08, 32'h00003000);
    wr(8'h10, 32'h00000001);
    chk("rts below level", 32'(rts_pin), 32'h1);
    wr(8'h00, 32'h000000A5);
    repeat (400) @(posedge aclk);
    rd(8'h2C);
    chk("held by cts", 32'(v[0]), 32'h0);
    cts_lvl <= 1'b1;
    poll(8'h2C, 0, 1'b1);
    chk("rts at level", 32'(rts_pin), 32'h0);
    rd(8'h10);
    chk("cts changed", 32'(v[0]), 32'h1);
    rd(8'h00);
    chk("echo byte", 32'(v[7:0]), 32'hA5);
    chk("rts back", 32'(rts_pin), 32'h1);
    $display("test flow done");
    wr(8'h24, 32'h00000001);
    wr(8'h18, 32'h000B0500);
    poll(8'h1C, 8, 1'b1);
    chk("break seen", 32'(v[8]), 32'h1);
    poll(8'h18, 8, 1'b0);
    chk("header done", 32'(v[8]), 32'h0);
    drain(last);
    wr(8'h00, 32'h00000055);
    poll(8'h2C, 0, 1'b1);
    rd(8'h00);
    chk("sync echo", 32'(v[7:0]), 32'h55);
    wr(8'h18, 32'h018B1300);
    poll(8'h18, 8, 1'b0);
    drain(last);
    chk("id with parity", 32'(last), 32'hC1);
    rd(8'h1C);
    chk("no bit error", 32'(v[9]), 32'h0);
    $display("test lin done");
    wr(8'h24, 32'h00000002);
    ir_on <= 1'b1;
    wr(8'h00, 32'h00000000);
    repeat (300) @(posedge aclk);
    chk("ir light ticks", 32'(ir_hi), 32'h1B);
    $display("test irda done");
    final_report();
  end
endmodule // tb_top
